/* File: clk_enable_controller.sv */
// Controller end: APB registers and a two-wire write sequencer.
// Assumes APB runs on CORE_CLK at 200 MHz and no clock stretching.
`default_nettype none
module clk_enable_controller (
  // Core clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial link.
  i2c_link_if.controller LINK
);
  // ==========================================================================
  // Declarations.
  clk_en_pkg::ctl_state_e state_r, state_nxt;
  logic [15:0] enable_r;
  logic nack_r, ack_bad_r, scl_low_r, sda_low_r;
  logic [8:0] q_cnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [2:0] idx_r;
  logic [7:0] tx_r;
  logic [31:0] prdata_r;
  logic pslverr_r, sda_meta_r, sda_s_r;
  logic idle, wr_fire, hit, go, tick, ph_end, nack_set;

  // ==========================================================================
  // APB decode; a write takes effect at the access edge, read data is set at the setup edge.
  assign idle = (state_r == clk_en_pkg::C_IDLE);
  assign wr_fire = PSEL & PENABLE & PWRITE;
  assign hit = (PADDR == clk_en_pkg::OFS_CTRL) | (PADDR == clk_en_pkg::OFS_ENABLE) |
               (PADDR == clk_en_pkg::OFS_STATUS);
  assign go = wr_fire & idle & (PADDR == clk_en_pkg::OFS_CTRL) & PWDATA[clk_en_pkg::CTRL_GO_BIT];
  assign PREADY = 1'b1;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else if (PSEL & ~PENABLE) begin
      pslverr_r <= ~hit;
      prdata_r <= 32'h0;
      if (PADDR == clk_en_pkg::OFS_ENABLE) begin
        prdata_r <= {16'h0, enable_r};
      end
      if (PADDR == clk_en_pkg::OFS_STATUS) begin
        prdata_r <= {30'h0, nack_r, ~idle};
      end
    end
  end

  // Enable image is writable only while idle.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_r <= clk_en_pkg::ENABLE_RESET;
    end else if (wr_fire & idle & (PADDR == clk_en_pkg::OFS_ENABLE)) begin
      enable_r <= PWDATA[15:0];
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      nack_r <= 1'b0;
    end else if (nack_set) begin
      nack_r <= 1'b1;
    end else if (wr_fire & (PADDR == clk_en_pkg::OFS_STATUS) &
                 PWDATA[clk_en_pkg::STATUS_NACK_BIT]) begin
      nack_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Quarter-bit timebase keeps the serial clock at 100 kHz.
  assign tick = ~idle & (q_cnt_r == clk_en_pkg::QUARTER_LAST);
  assign ph_end = tick & (ph_r == clk_en_pkg::PH_LAST);
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      q_cnt_r <= 9'h0;
      ph_r <= 2'h0;
    end else if (idle | tick) begin
      q_cnt_r <= 9'h0;
      ph_r <= idle ? 2'h0 : ph_r + 2'h1;
    end else begin
      q_cnt_r <= q_cnt_r + 9'h1;
    end
  end

  // Sequence state: start, nine-bit slots, stop, then bus free time.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clk_en_pkg::C_IDLE: if (go) state_nxt = clk_en_pkg::C_START;
      clk_en_pkg::C_START: if (ph_end) state_nxt = clk_en_pkg::C_BIT;
      clk_en_pkg::C_BIT: begin
        if (ph_end & (bit_r == clk_en_pkg::BITS_PER_BYTE) &
            (ack_bad_r | (idx_r == clk_en_pkg::IDX_DATA1))) begin
          state_nxt = clk_en_pkg::C_STOP;
        end
      end
      clk_en_pkg::C_STOP: if (ph_end) state_nxt = clk_en_pkg::C_FREE;
      clk_en_pkg::C_FREE: if (ph_end) state_nxt = clk_en_pkg::C_IDLE;
      default: state_nxt = clk_en_pkg::C_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= clk_en_pkg::C_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign nack_set = ph_end & (state_r == clk_en_pkg::C_BIT) &
                    (bit_r == clk_en_pkg::BITS_PER_BYTE) & ack_bad_r;

  // Byte stream: address, two dummies, then both enable bytes.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_r <= 4'h0;
      idx_r <= 3'h0;
      tx_r <= 8'h0;
    end else if (ph_end & (state_r == clk_en_pkg::C_START)) begin
      bit_r <= 4'h0;
      idx_r <= clk_en_pkg::IDX_ADDR;
      tx_r <= clk_en_pkg::TARGET_ADDR_W;
    end else if (ph_end & (state_r == clk_en_pkg::C_BIT)) begin
      if (bit_r == clk_en_pkg::BITS_PER_BYTE) begin
        bit_r <= 4'h0;
        idx_r <= idx_r + 3'h1;
        case (idx_r + 3'h1)
          clk_en_pkg::IDX_CMD: tx_r <= clk_en_pkg::CMD_DUMMY;
          clk_en_pkg::IDX_COUNT: tx_r <= clk_en_pkg::COUNT_DUMMY;
          clk_en_pkg::IDX_DATA0: tx_r <= enable_r[15:8];
          default: tx_r <= enable_r[7:0];
        endcase
      end else begin
        bit_r <= bit_r + 4'h1;
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Data line in: two flip-flops, then the acknowledge sample mid-high.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      ack_bad_r <= 1'b0;
    end else begin
      sda_meta_r <= LINK.sda_line;
      sda_s_r <= sda_meta_r;
      if (tick & (ph_r == 2'h2) & (state_r == clk_en_pkg::C_BIT) &
          (bit_r == clk_en_pkg::BITS_PER_BYTE)) begin
        ack_bad_r <= sda_s_r;
      end
    end
  end

  // Lines out: clock low in quarters 0-1, bit data changes in quarter 1, start and stop edges come while the clock is high.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (tick) begin
      // Low for the two quarters entered from quarter 3 and quarter 0.
      scl_low_r <= ((state_nxt == clk_en_pkg::C_BIT) | (state_nxt == clk_en_pkg::C_STOP)) &
                   ((ph_r == clk_en_pkg::PH_LAST) | (ph_r == 2'h0));
      if ((state_r == clk_en_pkg::C_START) & (ph_r == 2'h1)) begin
        sda_low_r <= 1'b1;
      end else if ((state_r == clk_en_pkg::C_BIT) & (ph_r == 2'h0)) begin
        sda_low_r <= (bit_r != clk_en_pkg::BITS_PER_BYTE) & ~tx_r[7];
      end else if ((state_r == clk_en_pkg::C_STOP) & (ph_r == 2'h0)) begin
        sda_low_r <= 1'b1;
      end else if (ph_end & (state_r == clk_en_pkg::C_STOP)) begin
        sda_low_r <= 1'b0;
      end
    end
  end
  assign LINK.host_scl_o = 1'b0;
  assign LINK.host_scl_oe_b = ~scl_low_r;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.host_sda_oe_b = ~sda_low_r;
endmodule
`default_nettype wire

/* File: clk_en_pkg.sv */
// Shared constants and state types for the clock-pair enable link.
// Assumes both ends and the bench compile this package first.
`default_nettype none
package clk_en_pkg;
  // ==========================================================================
  // Target side: address, dummy bytes and enable image.
  localparam int NUM_PAIRS = 10;
  localparam int ENABLE_MSB = 15;
  localparam logic [7:0] TARGET_ADDR_W = 8'hD2;
  localparam logic [7:0] CMD_DUMMY = 8'h00;
  localparam logic [7:0] COUNT_DUMMY = 8'h02;
  localparam logic [15:0] ENABLE_RESET = 16'hFFC0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] IDX_ADDR = 3'h0;
  localparam logic [2:0] IDX_CMD = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_DATA0 = 3'h3;
  localparam logic [2:0] IDX_DATA1 = 3'h4;
  localparam logic [2:0] IDX_LAST = 3'h5;
  // ==========================================================================
  // Serial clock timing, one bit cut into four equal quarters.
  localparam int SCL_MAX_KHZ = 100;
  localparam int CORE_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
  localparam logic [8:0] QUARTER_LAST = 9'(QUARTER_CYC - 1);
  localparam logic [1:0] PH_LAST = 2'h3;
  // ==========================================================================
  // Controller registers on APB.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_GO_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_NACK_BIT = 1;
  // ==========================================================================
  // State types.
  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_RECV = 2'h1,
    T_ACK = 2'h3,
    T_SKIP = 2'h2
  } tgt_state_e;
  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_START = 3'h1,
    C_BIT = 3'h3,
    C_STOP = 3'h2,
    C_FREE = 3'h6
  } ctl_state_e;
endpackage
`default_nettype wire

/* File: i2c_link_if.sv */
// Two-wire link carrier joining the controller and the target.
// Assumes a pull-up on both lines; each driver only ever pulls low.
`default_nettype none
interface i2c_link_if;
  // ==========================================================================
  // Drivers: output value and active-low enable per party.
  logic host_scl_o;
  logic host_scl_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  // Resolved wire levels.
  logic scl_line;
  logic sda_line;

  // A line is low when any enabled driver pulls it low.
  assign scl_line = ~(~host_scl_oe_b & ~host_scl_o);
  assign sda_line = ~((~host_sda_oe_b & ~host_sda_o) | (~dev_sda_oe_b & ~dev_sda_o));

  modport controller (
    output host_scl_o, host_scl_oe_b, host_sda_o, host_sda_oe_b,
    input scl_line, sda_line
  );
  modport target (
    output dev_sda_o, dev_sda_oe_b,
    input scl_line, sda_line
  );
endinterface
`default_nettype wire

/* File: clk_enable_target.sv */
// Target end: write-only enable register for ten clock output pairs.
// Assumes LINK_CLK runs free, far faster than the serial clock.
// How it works
// - Answer only write address byte D2.
// - Host sends command and count dummies first.
// - All ten pairs enabled after reset.
// - Enabled pair runs, disabled pair floats.
// - First data byte: high enables, low disables.
// - Host serial clock at most 100 kHz.
// - Start, stop and phases per bus standard.
// - Pull data low in acknowledge period.
// - Bytes map pairs 0-7, then 8-9.
// - Repeated start accepted; power down releases data.
`default_nettype none
module clk_enable_target (
  // Link clock domain.
  input wire logic LINK_CLK,
  input wire logic RST_B,
  // Serial link.
  i2c_link_if.target LINK,
  // Running clock source and power down pin.
  input wire logic PLL_CLK,
  input wire logic POWER_DOWN_INPUT_B,
  // Clock output pairs.
  output logic [clk_en_pkg::NUM_PAIRS-1:0] CLK_OUT,
  output logic [clk_en_pkg::NUM_PAIRS-1:0] CLK_OUT_N,
  output logic [clk_en_pkg::NUM_PAIRS-1:0] CLK_OUT_OE_B,
  // Enable image as last written.
  output logic [15:0] ENABLE_REG
);
  // ==========================================================================
  // Declarations.
  clk_en_pkg::tgt_state_e state_r;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [3:0] bit_r;
  logic [2:0] idx_r;
  logic [7:0] shift_r;
  logic [15:0] enable_r;
  logic ack_r;
  logic scl_s;
  logic sda_s;
  logic pd_b_s;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic accept;
  logic ack_end;

  // ==========================================================================
  // Pin inputs pass two flip-flops before any logic reads them.
  // Bit 0 is the clock line, bit 1 the data line, bit 2 the power down pin.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r <= 3'h7;
      sync_r <= 3'h7;
    end else begin
      meta_r <= {POWER_DOWN_INPUT_B, LINK.sda_line, LINK.scl_line};
      sync_r <= meta_r;
    end
  end
  assign scl_s = sync_r[0];
  assign sda_s = sync_r[1];
  assign pd_b_s = sync_r[2];

  // Previous samples feed the edge and condition detectors.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  // ==========================================================================
  // Conditions: data moving while the clock stays high is start or stop.
  // A start seen mid-transfer simply restarts the address phase.
  assign start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;

  // A byte is complete at the clock fall after its eighth rise.
  assign byte_done = (state_r == clk_en_pkg::T_RECV) & scl_fall &
                     (bit_r == clk_en_pkg::BITS_PER_BYTE);
  // Only the write address is taken; read direction or other address is not.
  assign accept = (idx_r != clk_en_pkg::IDX_ADDR) |
                  (shift_r == clk_en_pkg::TARGET_ADDR_W);
  // The acknowledge slot ends at the next clock fall.
  assign ack_end = (state_r == clk_en_pkg::T_ACK) & scl_fall;

  // ==========================================================================
  // Transfer state: receive, acknowledge, or sit out a refused transfer.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= clk_en_pkg::T_IDLE;
    end else if (start_det) begin
      state_r <= clk_en_pkg::T_RECV;
    end else if (stop_det) begin
      state_r <= clk_en_pkg::T_IDLE;
    end else begin
      case (state_r)
        clk_en_pkg::T_RECV: begin
          if (byte_done) begin
            state_r <= accept ? clk_en_pkg::T_ACK : clk_en_pkg::T_SKIP;
          end
        end
        clk_en_pkg::T_ACK: begin
          if (scl_fall) begin
            state_r <= clk_en_pkg::T_RECV;
          end
        end
        clk_en_pkg::T_IDLE: state_r <= clk_en_pkg::T_IDLE;
        clk_en_pkg::T_SKIP: state_r <= clk_en_pkg::T_SKIP;
        default: state_r <= clk_en_pkg::T_IDLE;
      endcase
    end
  end

  // Bit counter: counts clock rises of the eight data bits of a byte.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_r <= 4'h0;
    end else if (start_det | ack_end) begin
      bit_r <= 4'h0;
    end else if ((state_r == clk_en_pkg::T_RECV) & scl_rise &
                 (bit_r != clk_en_pkg::BITS_PER_BYTE)) begin
      bit_r <= bit_r + 4'h1;
    end
  end

  // Shift register samples the data line on each clock rise, MSB first.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      shift_r <= 8'h0;
    end else if ((state_r == clk_en_pkg::T_RECV) & scl_rise) begin
      shift_r <= {shift_r[6:0], sda_s};
    end
  end

  // Byte index: address, command dummy, count dummy, two data, then beyond.
  // It saturates so that any further bytes fall in the ignored slot.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      idx_r <= clk_en_pkg::IDX_ADDR;
    end else if (start_det) begin
      idx_r <= clk_en_pkg::IDX_ADDR;
    end else if (ack_end & (idx_r != clk_en_pkg::IDX_LAST)) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  // ==========================================================================
  // Enable image: reset enables all ten pairs, reserved bits low.
  // Data bytes land in order; dummies and extra bytes change nothing.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_r <= clk_en_pkg::ENABLE_RESET;
    end else if (byte_done) begin
      if (idx_r == clk_en_pkg::IDX_DATA0) begin
        enable_r[15:8] <= shift_r;
      end
      if (idx_r == clk_en_pkg::IDX_DATA1) begin
        enable_r[7:0] <= shift_r;
      end
    end
  end
  assign ENABLE_REG = enable_r;

  // ==========================================================================
  // Acknowledge drive: held from the byte's last fall to the next fall.
  // A start or stop always lets the line go so the bus cannot hang.
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_r <= 1'b0;
    end else if (byte_done & accept) begin
      ack_r <= 1'b1;
    end else if (ack_end | start_det | stop_det) begin
      ack_r <= 1'b0;
    end
  end

  // Open drain: only ever pulls low, and never while powered down.
  assign LINK.dev_sda_o = 1'b0;
  assign LINK.dev_sda_oe_b = ~(ack_r & pd_b_s);

  // ==========================================================================
  // Output pairs: running clock while enabled, floating while disabled.
  // Byte bit 7 is pair 0, so pair i follows image bit 15 - i.
  // The enable is a slow static level, so it gates the clock pins directly.
  for (genvar i = 0; i < clk_en_pkg::NUM_PAIRS; i++) begin : g_pair
    assign CLK_OUT[i] = PLL_CLK;
    assign CLK_OUT_N[i] = ~PLL_CLK;
    assign CLK_OUT_OE_B[i] = ~enable_r[clk_en_pkg::ENABLE_MSB - i];
  end
endmodule
`default_nettype wire

/* File: clk_en_link_sva.sv */
// Checker for the two-wire link: bus phase timing and acknowledge pulls.
// Assumes it sits beside the link that joins the controller and the target.
`default_nettype none
module clk_en_link_sva (
  // Clocks and reset.
  input wire logic CORE_CLK,
  input wire logic LINK_CLK,
  input wire logic RST_B,
  // Link signals.
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Run lengths
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [15:0] per_r;
  logic [15:0] ack_r;

  // Saturating counts of SCL high, SCL low, SCL period and acknowledge pull.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
      per_r <= 16'h0000;
      ack_r <= 16'h0000;
    end else begin
      hi_r <= !scl_line ? 16'h0000 : (&hi_r) ? hi_r : hi_r + 16'h0001;
      lo_r <= scl_line ? 16'h0000 : (&lo_r) ? lo_r : lo_r + 16'h0001;
      per_r <= $rose(scl_line) ? 16'h0001 : (&per_r) ? per_r : per_r + 16'h0001;
      ack_r <= dev_sda_oe_b ? 16'h0000 : (&ack_r) ? ack_r : ack_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Properties
  property p_scl_low_min;
    @(posedge CORE_CLK) disable iff (!RST_B) $rose(scl_line) |-> lo_r >= 16'h03AC;
  endproperty
  a_scl_low_min: assert property (p_scl_low_min) else $error("SCL low too short");
  property p_scl_high_min;
    @(posedge CORE_CLK) disable iff (!RST_B) $fell(scl_line) |-> hi_r >= 16'h0320;
  endproperty
  a_scl_high_min: assert property (p_scl_high_min) else $error("SCL high too short");
  property p_scl_period;
    @(posedge CORE_CLK) disable iff (!RST_B) $rose(scl_line) |-> per_r >= 16'h07D0;
  endproperty
  a_scl_period: assert property (p_scl_period) else $error("SCL too fast");
  property p_start_setup;
    @(posedge CORE_CLK) disable iff (!RST_B) $fell(sda_line) && scl_line |-> hi_r >= 16'h03AC;
  endproperty
  a_start_setup: assert property (p_start_setup) else $error("Start setup short");
  property p_stop_setup;
    @(posedge CORE_CLK) disable iff (!RST_B) $rose(sda_line) && scl_line |-> hi_r >= 16'h0320;
  endproperty
  a_stop_setup: assert property (p_stop_setup) else $error("Stop setup short");
  property p_dev_pull_low;
    @(posedge LINK_CLK) disable iff (!RST_B) !dev_sda_oe_b |-> !dev_sda_o;
  endproperty
  a_dev_pull_low: assert property (p_dev_pull_low) else $error("Target drives high");
  property p_dev_change_scl_low;
    @(posedge LINK_CLK) disable iff (!RST_B) $changed(dev_sda_oe_b) |-> !scl_line;
  endproperty
  a_dev_change_scl_low: assert property (p_dev_change_scl_low) else $error("Pull moved");
  property p_ack_len;
    @(posedge CORE_CLK) disable iff (!RST_B)
      $rose(dev_sda_oe_b) |-> ack_r >= 16'h076C && ack_r <= 16'h0834;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("Ack not one bit long");
endmodule
`default_nettype wire

/* File: clk_output_enable_serial_slave_test.sv */
// Bench: APB-driven controller and target on one link, bit-banged target on a second.
// Assumes the package, the link carrier and both ends are compiled first.
`default_nettype none
module clk_output_enable_serial_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Signals
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic pll_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic pd_b = 1'b1;
  logic [9:0] out1, out1_n, oe1, out2, out2_n, oe2;
  logic [15:0] en1, en2;
  int n_errors = 0;
  int total_checks = 0;
  i2c_link_if link ();
  i2c_link_if link2 ();

  // Clocks of unrelated phase.
  always #2.5 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  always #4 pll_clk = ~pll_clk;

  // ==========================================================================
  // Design and checker
  clk_enable_controller u_clk_enable_controller (
    .CORE_CLK(core_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK(link)
  );
  clk_enable_target u_clk_enable_target (
    .LINK_CLK(link_clk), .RST_B(rst_b), .LINK(link), .PLL_CLK(pll_clk),
    .POWER_DOWN_INPUT_B(1'b1), .CLK_OUT(out1), .CLK_OUT_N(out1_n), .CLK_OUT_OE_B(oe1),
    .ENABLE_REG(en1)
  );
  clk_enable_target u_clk_enable_target_b (
    .LINK_CLK(link_clk), .RST_B(rst_b), .LINK(link2), .PLL_CLK(pll_clk),
    .POWER_DOWN_INPUT_B(pd_b), .CLK_OUT(out2), .CLK_OUT_N(out2_n), .CLK_OUT_OE_B(oe2),
    .ENABLE_REG(en2)
  );
  clk_en_link_sva u_clk_en_link_sva (
    .CORE_CLK(core_clk), .LINK_CLK(link_clk), .RST_B(rst_b), .scl_line(link.scl_line),
    .sda_line(link.sda_line), .dev_sda_o(link.dev_sda_o), .dev_sda_oe_b(link.dev_sda_oe_b)
  );

  // ==========================================================================
  // Tasks
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // One APB transfer; read data taken at the edge where PREADY is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Quarter bit waits keep the serial clock at its 100 kHz ceiling.
  task automatic qw(input int n);
    repeat (n * clk_en_pkg::QUARTER_CYC) @(posedge core_clk);
  endtask

  // One bit on the second link; the line level is sampled mid SCL high.
  task automatic lbit(input logic b, output logic s);
    link2.host_scl_oe_b <= 1'b0;
    qw(1);
    link2.host_sda_oe_b <= b;
    qw(1);
    link2.host_scl_oe_b <= 1'b1;
    qw(1);
    s = link2.sda_line;
    qw(1);
  endtask

  // A byte MSB first, then the acknowledge slot with SDA released.
  task automatic lbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) lbit(v[i], s);
    lbit(1'b1, ack);
  endtask

  // Start or repeated start with full setup and hold.
  task automatic lstart;
    link2.host_sda_oe_b <= 1'b1;
    link2.host_scl_oe_b <= 1'b1;
    qw(2);
    link2.host_sda_oe_b <= 1'b0;
    qw(2);
  endtask

  // Stop: SDA rises while SCL is high.
  task automatic lstop;
    link2.host_scl_oe_b <= 1'b0;
    qw(1);
    link2.host_sda_oe_b <= 1'b0;
    qw(1);
    link2.host_scl_oe_b <= 1'b1;
    qw(2);
    link2.host_sda_oe_b <= 1'b1;
    qw(1);
  endtask

  // Pair i is driven when enable image bit 15-i is set.
  function automatic logic [31:0] exp_oe(input logic [15:0] e);
    exp_oe = 32'h00000000;
    for (int i = 0; i < clk_en_pkg::NUM_PAIRS; i++) exp_oe[i] = ~e[15 - i];
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog sized for two transfers running side by side.
  initial begin
    repeat (150000) @(posedge core_clk);
    n_errors++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic err, ack;
    link2.host_scl_o = 1'b0;
    link2.host_sda_o = 1'b0;
    link2.host_scl_oe_b = 1'b1;
    link2.host_sda_oe_b = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk("ENABLE_REG", 32'h0000FFC0, {16'h0000, en1});
    chk("CLK_OUT_OE_B", 32'h00000000, {22'h000000, oe1});
    chk("CLK_OUT", {22'h000000, {10{pll_clk}}}, {22'h000000, out1});
    chk("CLK_OUT_N", {22'h000000, ~{10{pll_clk}}}, {22'h000000, out1_n});
    chk("CLK_OUT_OE_B b", 32'h00000000, {22'h000000, oe2});
    chk("CLK_OUT b", {22'h000000, {10{pll_clk}}}, {22'h000000, out2});
    chk("CLK_OUT_N b", {22'h000000, ~{10{pll_clk}}}, {22'h000000, out2_n});
    chk("PREADY", 32'h00000001, {31'h00000000, pready});
    apb(1'b0, clk_en_pkg::OFS_ENABLE, 32'h00000000, rd, err);
    chk("ENABLE", 32'h0000FFC0, rd);
    apb(1'b0, 8'h0C, 32'h00000000, rd, err);
    chk("PSLVERR", 32'h00000001, {31'h00000000, err});
    apb(1'b1, clk_en_pkg::OFS_ENABLE, 32'h0000A540, rd, err);
    fork
      begin
        apb(1'b1, clk_en_pkg::OFS_CTRL, 32'h00000001, rd, err);
        // A write to the enable image while busy must be ignored.
        apb(1'b1, clk_en_pkg::OFS_ENABLE, 32'h0000FFC0, rd, err);
        apb(1'b0, clk_en_pkg::OFS_ENABLE, 32'h00000000, rd, err);
        chk("ENABLE busy", 32'h0000A540, rd);
        apb(1'b0, clk_en_pkg::OFS_STATUS, 32'h00000000, rd, err);
        chk("busy", 32'h00000001, {31'h00000000, rd[0]});
        for (int k = 0; k < 2000 && rd[0] === 1'b1; k++) begin
          repeat (100) @(posedge core_clk);
          apb(1'b0, clk_en_pkg::OFS_STATUS, 32'h00000000, rd, err);
        end
        chk("STATUS", 32'h00000000, {30'h00000000, rd[1:0]});
        chk("ENABLE_REG", 32'h0000A540, {16'h0000, en1});
        chk("CLK_OUT_OE_B", exp_oe(16'hA540), {22'h000000, oe1});
      end
      begin
        lstart();
        lbyte(8'hD3, ack);
        chk("ack read", 32'h00000001, {31'h00000000, ack});
        lstart();
        lbyte(clk_en_pkg::TARGET_ADDR_W, ack);
        chk("ack address", 32'h00000000, {31'h00000000, ack});
        lbyte(clk_en_pkg::CMD_DUMMY, ack);
        chk("ack command", 32'h00000000, {31'h00000000, ack});
        pd_b <= 1'b0;
        lbyte(clk_en_pkg::COUNT_DUMMY, ack);
        chk("ack power down", 32'h00000001, {31'h00000000, ack});
        pd_b <= 1'b1;
        lbyte(8'h55, ack);
        chk("ack data0", 32'h00000000, {31'h00000000, ack});
        lbyte(8'h7F, ack);
        chk("ack data1", 32'h00000000, {31'h00000000, ack});
        lstop();
        chk("ENABLE_REG b", 32'h0000557F, {16'h0000, en2});
        chk("CLK_OUT_OE_B b", exp_oe(16'h557F), {22'h000000, oe2});
      end
    join
    test_done();
  end
endmodule
`default_nettype wire
